// File: design/motor_config_register_bank.sv
// Configuration and control register bank of a sensorless motor driver
`include "motor_cfg_defs.svh"

module motor_config_register_bank (
  input wire logic CLK_SYS_IN,
  input wire logic RST_IN,
  input wire logic SHADOW_USE_ENABLE_IN,
  input wire logic [15:0] EEPROM_CFG1_IN,
  input wire logic [15:0] EEPROM_CFG2_IN,
  input wire logic WR_EN_IN,
  input wire logic RD_EN_IN,
  input wire logic [7:0] ADDR_IN,
  input wire logic [15:0] WDATA_IN,
  output logic [15:0] RDATA_OUT,
  output logic MOTOR_OFF_OUT,
  output logic [1:0] DITHER_SELECT_OUT,
  output logic [1:0] TACH_LOOP_GATING_OUT,
  output logic [4:0] TACH_DIVISOR_OUT,
  output logic CYCLE_ADJUST_SELECT_OUT,
  output logic [18:0] RESISTANCE_OUT,
  output logic [10:0] EMF_CONSTANT_OUT,
  output logic ADVANCE_MODE_SELECT_OUT,
  output logic [10:0] ADVANCE_TIME_OUT
);
  motor_cfg_pkg::state_type state_reg;
  motor_cfg_pkg::state_type state_next;
  motor_cfg_pkg::cfg_one_type eff_one;
  motor_cfg_pkg::cfg_two_type eff_two;

  always_comb begin
    state_next = state_reg;
    if (WR_EN_IN) begin
      // Unmapped addresses fall through with no effect
      case (ADDR_IN)
        `ADDR_CTRL: state_next.motor_off_bit = WDATA_IN[`MOTOR_OFF_POS];
        `ADDR_CFG1: state_next.cfg_one = WDATA_IN;
        // Reserved bit is masked so a careless host cannot make it read back
        `ADDR_CFG2: state_next.cfg_two = WDATA_IN & `CFG2_RESERVED_MASK;
        default: state_next.rdata = state_reg.rdata;
      endcase
    end
    // Shadow values drive operation only when enabled; else stored copy
    eff_one = SHADOW_USE_ENABLE_IN ? state_next.cfg_one : EEPROM_CFG1_IN;
    eff_two = SHADOW_USE_ENABLE_IN ? state_next.cfg_two : EEPROM_CFG2_IN;
    if (RD_EN_IN) begin
      case (ADDR_IN)
        `ADDR_CTRL: state_next.rdata = 16'h0000;
        `ADDR_CFG1: state_next.rdata = eff_one;
        `ADDR_CFG2: state_next.rdata = eff_two & `CFG2_RESERVED_MASK;
        default: state_next.rdata = 16'h0000;
      endcase
    end
    state_next.tach_div = {1'b0, eff_one.tach_pole_divider} + 5'h01;
    state_next.resistance = 19'({15'h0000, eff_one.resistance_significand}
      << eff_one.resistance_shift);
    state_next.emf_constant = 11'({7'h00, eff_two.emf_constant_significand}
      << eff_two.emf_constant_shift);
    state_next.advance_time = 11'({7'h00, eff_two.advance_time_significand}
      << eff_two.advance_time_shift);
    state_next.dither = eff_one.dither_select;
    state_next.gating = eff_one.tach_loop_gating;
    state_next.cycle_adjust = eff_one.cycle_adjust_select;
    state_next.advance_mode = eff_two.advance_mode_select;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (RST_IN) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output is a field of the one state register, so none is combinational
  assign RDATA_OUT = state_reg.rdata;
  assign MOTOR_OFF_OUT = state_reg.motor_off_bit;
  assign DITHER_SELECT_OUT = state_reg.dither;
  assign TACH_LOOP_GATING_OUT = state_reg.gating;
  assign TACH_DIVISOR_OUT = state_reg.tach_div;
  assign CYCLE_ADJUST_SELECT_OUT = state_reg.cycle_adjust;
  assign RESISTANCE_OUT = state_reg.resistance;
  assign EMF_CONSTANT_OUT = state_reg.emf_constant;
  assign ADVANCE_MODE_SELECT_OUT = state_reg.advance_mode;
  assign ADVANCE_TIME_OUT = state_reg.advance_time;

  property p_ctrl_reads_zero;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (RD_EN_IN && ADDR_IN == `ADDR_CTRL) |=> (RDATA_OUT == 16'h0000);
  endproperty
  a_ctrl_reads_zero: assert property (p_ctrl_reads_zero)
    else $error("control read nonzero");

  property p_motor_off;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (WR_EN_IN && ADDR_IN == `ADDR_CTRL) |=> (MOTOR_OFF_OUT == $past(WDATA_IN[15]));
  endproperty
  a_motor_off: assert property (p_motor_off)
    else $error("motor off not taken");

  property p_unused_a;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (RD_EN_IN && ADDR_IN >= `UNUSED_A_LO && ADDR_IN <= `UNUSED_A_HI)
      |=> (RDATA_OUT == 16'h0000);
  endproperty
  a_unused_a: assert property (p_unused_a)
    else $error("unused low range read nonzero");

  property p_unused_b;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (WR_EN_IN && ADDR_IN >= `UNUSED_B_LO && ADDR_IN <= `UNUSED_B_HI)
      |=> $stable(state_reg.cfg_one) && $stable(state_reg.cfg_two) && $stable(MOTOR_OFF_OUT);
  endproperty
  a_unused_b: assert property (p_unused_b)
    else $error("unused write changed state");

  property p_unused_b_read;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (RD_EN_IN && ADDR_IN >= `UNUSED_B_LO && ADDR_IN <= `UNUSED_B_HI)
      |=> (RDATA_OUT == 16'h0000);
  endproperty
  a_unused_b_read: assert property (p_unused_b_read)
    else $error("unused high range read nonzero");

  property p_cfg2_reserved;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (RD_EN_IN && ADDR_IN == `ADDR_CFG2) |=> (RDATA_OUT[15] == 1'b0);
  endproperty
  a_cfg2_reserved: assert property (p_cfg2_reserved)
    else $error("reserved bit read set");

  property p_shadow_readback;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (SHADOW_USE_ENABLE_IN && RD_EN_IN && !WR_EN_IN && ADDR_IN == `ADDR_CFG1)
      |=> (RDATA_OUT == state_reg.cfg_one);
  endproperty
  a_shadow_readback: assert property (p_shadow_readback)
    else $error("shadow readback wrong");

  // With the shadow copy off a read must show the stored copy, not the last write
  property p_stored_readback;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (!SHADOW_USE_ENABLE_IN && RD_EN_IN && ADDR_IN == `ADDR_CFG1)
      |=> (RDATA_OUT == $past(EEPROM_CFG1_IN));
  endproperty
  a_stored_readback: assert property (p_stored_readback)
    else $error("stored copy readback wrong");

  property p_tach_div;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (SHADOW_USE_ENABLE_IN && WR_EN_IN && ADDR_IN == `ADDR_CFG1)
      |=> (TACH_DIVISOR_OUT == {1'b0, $past(WDATA_IN[11:8])} + 5'h01);
  endproperty
  a_tach_div: assert property (p_tach_div)
    else $error("tach divisor wrong");

  property p_dither;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (SHADOW_USE_ENABLE_IN && WR_EN_IN && ADDR_IN == `ADDR_CFG1)
      |=> (DITHER_SELECT_OUT == $past(WDATA_IN[15:14]));
  endproperty
  a_dither: assert property (p_dither)
    else $error("dither select wrong");

  property p_gating;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (SHADOW_USE_ENABLE_IN && WR_EN_IN && ADDR_IN == `ADDR_CFG1)
      |=> (TACH_LOOP_GATING_OUT == $past(WDATA_IN[13:12]));
  endproperty
  a_gating: assert property (p_gating)
    else $error("tach gating wrong");

  property p_cycle_adjust;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (SHADOW_USE_ENABLE_IN && WR_EN_IN && ADDR_IN == `ADDR_CFG1)
      |=> (CYCLE_ADJUST_SELECT_OUT == $past(WDATA_IN[7]));
  endproperty
  a_cycle_adjust: assert property (p_cycle_adjust)
    else $error("cycle adjust wrong");

  property p_resistance;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (SHADOW_USE_ENABLE_IN && WR_EN_IN && ADDR_IN == `ADDR_CFG1)
      |=> (RESISTANCE_OUT == ({15'h0000, $past(WDATA_IN[3:0])} << $past(WDATA_IN[6:4])));
  endproperty
  a_resistance: assert property (p_resistance)
    else $error("phase resistance wrong");

  property p_emf_constant;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (SHADOW_USE_ENABLE_IN && WR_EN_IN && ADDR_IN == `ADDR_CFG2)
      |=> (EMF_CONSTANT_OUT == ({7'h00, $past(WDATA_IN[11:8])} << $past(WDATA_IN[14:12])));
  endproperty
  a_emf_constant: assert property (p_emf_constant)
    else $error("back emf constant wrong");

  property p_advance_mode;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (SHADOW_USE_ENABLE_IN && WR_EN_IN && ADDR_IN == `ADDR_CFG2)
      |=> (ADVANCE_MODE_SELECT_OUT == $past(WDATA_IN[7]));
  endproperty
  a_advance_mode: assert property (p_advance_mode)
    else $error("advance mode wrong");

  property p_advance_time;
    @(posedge CLK_SYS_IN) disable iff (RST_IN)
      (SHADOW_USE_ENABLE_IN && WR_EN_IN && ADDR_IN == `ADDR_CFG2)
      |=> (ADVANCE_TIME_OUT == ({7'h00, $past(WDATA_IN[3:0])} << $past(WDATA_IN[6:4])));
  endproperty
  a_advance_time: assert property (p_advance_time)
    else $error("advance time wrong");

  property p_reset_zero;
    @(posedge CLK_SYS_IN) RST_IN |=> (MOTOR_OFF_OUT == 1'b0 && RDATA_OUT == 16'h0000);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("reset value nonzero");

  property p_reset_cfg;
    @(posedge CLK_SYS_IN) RST_IN
      |=> (state_reg.cfg_one == `CFG_RESET && state_reg.cfg_two == `CFG_RESET);
  endproperty
  a_reset_cfg: assert property (p_reset_cfg)
    else $error("configuration not cleared by reset");
endmodule // motor_config_register_bank

// File: design/motor_cfg_defs.svh
// Register offsets, field positions and reset values of the motor configuration bank
`ifndef MOTOR_CFG_DEFS_SVH
`define MOTOR_CFG_DEFS_SVH
`define ADDR_CTRL 8'h60
`define ADDR_CFG1 8'h90
`define ADDR_CFG2 8'h91
`define UNUSED_A_LO 8'h37
`define UNUSED_A_HI 8'h5F
`define UNUSED_B_LO 8'h61
`define UNUSED_B_HI 8'h8F
`define MOTOR_OFF_POS 15
`define CFG2_RESERVED_MASK 16'h7FFF
`define CFG_RESET 16'h0000
`endif

// File: design/motor_cfg_pkg.sv
// Types of the motor configuration bank
package motor_cfg_pkg;
  typedef struct packed {
    logic [1:0] dither_select;
    logic [1:0] tach_loop_gating;
    logic [3:0] tach_pole_divider;
    logic cycle_adjust_select;
    logic [2:0] resistance_shift;
    logic [3:0] resistance_significand;
  } cfg_one_type;

  typedef struct packed {
    logic reserved;
    logic [2:0] emf_constant_shift;
    logic [3:0] emf_constant_significand;
    logic advance_mode_select;
    logic [2:0] advance_time_shift;
    logic [3:0] advance_time_significand;
  } cfg_two_type;

  typedef struct packed {
    logic motor_off_bit;
    cfg_one_type cfg_one;
    cfg_two_type cfg_two;
    logic [15:0] rdata;
    logic [4:0] tach_div;
    logic [18:0] resistance;
    logic [10:0] emf_constant;
    logic [10:0] advance_time;
    logic [1:0] dither;
    logic [1:0] gating;
    logic cycle_adjust;
    logic advance_mode;
  } state_type;
endpackage

// File: bench/host_model.sv
// Host model standing in for the serial master of the register bank
module host_model (
  input wire logic clk_in,
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [7:0] addr_out,
  output logic [15:0] wdata_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 16'h0000;
  end
  // One strobe per access, held over exactly one rising edge
  task automatic access(input logic wr, input logic [7:0] a, input logic [15:0] d);
    @(negedge clk_in);
    wr_en_out = wr;
    rd_en_out = ~wr;
    addr_out = a;
    wdata_out = d;
    @(negedge clk_in);
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    // Released lines must not keep looking valid
    addr_out = ~a;
    wdata_out = ~d;
  endtask
endmodule // host_model

// File: bench/motor_config_register_bank_bench.sv
// Self-checking bench of the motor configuration register bank
module motor_config_register_bank_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rst = 1'b1, shadow = 1'b1, wr, rd, rd_d = 1'b0, moff, cyc, amode;
  logic [1:0] dith, gate;
  logic [4:0] div;
  logic [18:0] res;
  logic [10:0] emf, adv;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, v1, v2, ee1 = 16'h0000, ee2 = 16'h0000;
  logic [7:0] un [4] = '{8'h37, 8'h5F, 8'h61, 8'h8F};
  logic [31:0] lfsr = 32'h2292;
  logic [15:0] exp_q [$];
  int errors = 0, samples_checked = 0;
  always #10 clk = ~clk;
  host_model u_host_model (.clk_in(clk), .wr_en_out(wr), .rd_en_out(rd), .addr_out(addr),
    .wdata_out(wdata));
  motor_config_register_bank u_motor_config_register_bank (.CLK_SYS_IN(clk), .RST_IN(rst),
    .SHADOW_USE_ENABLE_IN(shadow), .EEPROM_CFG1_IN(ee1), .EEPROM_CFG2_IN(ee2), .WR_EN_IN(wr),
    .RD_EN_IN(rd), .ADDR_IN(addr), .WDATA_IN(wdata), .RDATA_OUT(rdata), .MOTOR_OFF_OUT(moff),
    .DITHER_SELECT_OUT(dith), .TACH_LOOP_GATING_OUT(gate), .TACH_DIVISOR_OUT(div),
    .CYCLE_ADJUST_SELECT_OUT(cyc), .RESISTANCE_OUT(res), .EMF_CONSTANT_OUT(emf),
    .ADVANCE_MODE_SELECT_OUT(amode), .ADVANCE_TIME_OUT(adv));
  function automatic logic [15:0] rnd();
    repeat (16) lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[15:0];
  endfunction
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_exp(input logic [7:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    u_host_model.access(1'b0, a, 16'h0000);
  endtask
  task automatic cfg1_check(input logic [15:0] v);
    check("dither", dith, v[15:14]);
    check("gating", gate, v[13:12]);
    check("divisor", div, v[11:8] + 32'h1);
    check("cycle", cyc, v[7]);
    check("resistance", res, 19'(v[3:0]) << v[6:4]);
  endtask
  task automatic cfg2_check(input logic [15:0] v);
    check("emf", emf, 11'(v[11:8]) << v[14:12]);
    check("mode", amode, v[7]);
    check("advance", adv, 11'(v[3:0]) << v[6:4]);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // Read data is registered on the read edge and checked at the next falling edge
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      if (exp_q.size() == 0) check("queue", 32'h1, 32'h0);
      else check("rdata", rdata, exp_q.pop_front());
    end
  end
  initial begin
    repeat (5000) @(posedge clk);
    errors++;
    conclude();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    rd_exp(8'h60, 16'h0000);
    rd_exp(8'h90, 16'h0000);
    rd_exp(8'h91, 16'h0000);
    check("motor_off", moff, 1'b0);
    cfg1_check(16'h0000);
    cfg2_check(16'h0000);
    $display("test reset done");
    u_host_model.access(1'b1, 8'h60, 16'h8000);
    rd_exp(8'h60, 16'h0000);
    check("motor_off", moff, 1'b1);
    u_host_model.access(1'b1, 8'h60, 16'h7FFF);
    rd_exp(8'h60, 16'h0000);
    check("motor_off", moff, 1'b0);
    $display("test control done");
    for (int i = 0; i < 16; i++) begin
      v1 = rnd();
      v1[15:12] = 4'(i);
      // Reserved bit left clear by the host
      v2 = rnd() & 16'h7FFF;
      u_host_model.access(1'b1, 8'h90, v1);
      u_host_model.access(1'b1, 8'h91, v2);
      u_host_model.access(1'b1, un[i % 4], rnd());
      rd_exp(un[i % 4], 16'h0000);
      rd_exp(8'h90, v1);
      cfg1_check(v1);
      rd_exp(8'h91, v2);
      cfg2_check(v2);
    end
    $display("test configuration done");
    // Reset in mid-run must clear what the host has written
    u_host_model.access(1'b1, 8'h60, 16'h8000);
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    rd_exp(8'h90, 16'h0000);
    rd_exp(8'h91, 16'h0000);
    check("motor_off", moff, 1'b0);
    cfg1_check(16'h0000);
    cfg2_check(16'h0000);
    $display("test second reset done");
    shadow = 1'b0;
    ee1 = rnd();
    // Stored copy may carry the reserved bit; readback must still clear it
    ee2 = rnd();
    rd_exp(8'h90, ee1);
    cfg1_check(ee1);
    rd_exp(8'h91, ee2 & 16'h7FFF);
    cfg2_check(ee2);
    $display("test stored copy done");
    // Let the watcher take the last read before the verdict
    repeat (2) @(posedge clk);
    check("pending", exp_q.size(), 32'h0);
    conclude();
  end
endmodule // motor_config_register_bank_bench
